// ==== rtl/fnmc_pkg.sv ====
// Purpose: Shared constants and types for the fractional-N modulus control block.
// Assumes: All logic runs on the reference input clock.
// Notes: Timing counts are in reference clock cycles.
package fnmc_pkg;

	localparam int ACC_W = 3;
	localparam logic [3:0] MOD_FIVE = 4'h5;
	localparam logic [3:0] MOD_EIGHT = 4'h8;
	localparam logic FRAC_MODULUS_SELECT_SEL_EIGHT = 1'b1;
	localparam logic [ACC_W-1:0] ACC_RESET = 3'h0;

	// Compensation pulse width, in reference input periods.
	localparam int COMP_PULSE_CYC = 2;

	localparam int CNT_W = 12;
	localparam int AMP_W = 7;
	localparam int IAMP_W = 11;

	// Prescaler modulus count, as carried in the configuration.
	localparam logic [1:0] MODULI_TWO = 2'h0;
	localparam logic [1:0] MODULI_THREE = 2'h1;
	localparam logic [1:0] MODULI_FOUR = 2'h2;

	typedef enum logic [1:0] {
		FNMC_R1 = 2'b00,
		FNMC_R2 = 2'b01,
		FNMC_R3 = 2'b10,
		FNMC_R4 = 2'b11
	} fnmc_ratio_t;

	typedef struct packed {
		logic hi;
		logic lo;
	} fnmc_modctl_t;

	localparam fnmc_modctl_t MODCTL_R1 = 2'h1;
	localparam fnmc_modctl_t MODCTL_R2 = 2'h0;
	localparam fnmc_modctl_t MODCTL_R3 = 2'h2;
	localparam fnmc_modctl_t MODCTL_R4 = 2'h3;
	localparam fnmc_modctl_t MODCTL_RESET = 2'h1;

	typedef struct packed {
		logic [2:0]       frac_increment;
		logic             frac_modulus_select;
		logic [CNT_W-1:0] n1;
		logic [7:0]       n2;
		logic [3:0]       n23;
		logic [3:0]       n234;
		logic [1:0]       moduli;
		logic [1:0]       l_factor;
		logic [3:0]       k_factor;
		logic             main_disable;
	} fnmc_cfg_t;

endpackage

// ==== rtl/fnmc_accum.sv ====
// Purpose: Fractional accumulator with selectable modulus.
// Assumes: Step is a one-cycle pulse, one per comparison cycle.
// Notes: Two subtractions keep the remainder right even after a switch from modulus 8 to 5.
`timescale 1ns/10ps
module fnmc_accum (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     clear,
	input  wire logic                     step,
	input  wire logic [2:0]               frac_increment,
	input  wire logic                     frac_modulus_select,
	output logic [fnmc_pkg::ACC_W-1:0]    acc,
	output logic [fnmc_pkg::ACC_W-1:0]    acc_next,
	output logic                          wrap
);

	logic [3:0] modv;
	logic [3:0] sum;
	logic [3:0] rem1;
	logic [3:0] rem2;

	always_comb begin
		modv = (frac_modulus_select == fnmc_pkg::FRAC_MODULUS_SELECT_SEL_EIGHT) ? fnmc_pkg::MOD_EIGHT : fnmc_pkg::MOD_FIVE;
		sum = {1'b0, acc} + {1'b0, frac_increment};
		rem1 = (sum >= modv) ? sum - modv : sum;
		rem2 = (rem1 >= modv) ? rem1 - modv : rem1;
		acc_next = rem2[fnmc_pkg::ACC_W-1:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc <= fnmc_pkg::ACC_RESET;
		end else if (clear) begin
			acc <= fnmc_pkg::ACC_RESET;
		end else if (step) begin
			acc <= acc_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrap <= 1'b0;
		end else begin
			wrap <= step && !clear && (sum >= modv);
		end
	end

endmodule

// ==== rtl/fnmc_comp.sv ====
// Purpose: Jitter compensation pulse timing and amplitude.
// Assumes: Lead pulses are at least three cycles apart.
// Notes: Amplitudes are captured at the start so they stay steady for the whole pulse.
`timescale 1ns/10ps
module fnmc_comp (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       lead,
	input  wire logic [fnmc_pkg::ACC_W-1:0] acc,
	input  wire logic                       speed_up,
	input  wire logic [1:0]                 l_factor,
	input  wire logic [3:0]                 k_factor,
	output logic                            comp_pullup,
	output logic [fnmc_pkg::AMP_W-1:0]      comp_amp,
	output logic                            integral_comp_pulse,
	output logic [fnmc_pkg::IAMP_W-1:0]     integral_comp_amp
);

	logic [1:0]                    left;
	logic [2:0]                    shamt;
	logic [fnmc_pkg::AMP_W-1:0]    step_amp;
	logic [fnmc_pkg::IAMP_W-1:0]   int_amp;

	always_comb begin
		shamt = {1'b0, l_factor} + 3'h1;
		step_amp = {4'h0, acc};
		if (speed_up) begin
			step_amp = {4'h0, acc} << shamt;
		end
		int_amp = {4'h0, step_amp} * {7'h0, k_factor};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			comp_pullup <= 1'b0;
			left <= 2'h0;
		end else if (lead) begin
			comp_pullup <= 1'b1;
			left <= 2'(fnmc_pkg::COMP_PULSE_CYC - 1);
		end else if (comp_pullup) begin
			if (left == 2'h0) begin
				comp_pullup <= 1'b0;
			end else begin
				left <= left - 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			comp_amp <= 7'h00;
			integral_comp_pulse <= 1'b0;
			integral_comp_amp <= 11'h000;
		end else if (lead) begin
			comp_amp <= step_amp;
			integral_comp_pulse <= speed_up;
			integral_comp_amp <= speed_up ? int_amp : 11'h000;
		end else if (comp_pullup && left == 2'h0) begin
			comp_amp <= 7'h00;
			integral_comp_pulse <= 1'b0;
			integral_comp_amp <= 11'h000;
		end
	end

endmodule

// ==== rtl/fnmc_top.sv ====
// Purpose: Fractional-N modulus control for the main synthesiser loop.
// Assumes: Clock is the reference input; ref_div_lead comes from same-clock logic.
// Notes: Strobe and prescaler output are pins and are synchronised here.
`timescale 1ns/10ps
module fnmc_top (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic                          strobe_pin,
	input  wire logic                          prescaler_pin,
	input  wire logic                          ref_div_lead,
	input  wire logic                          speed_word_sel,
	input  wire fnmc_pkg::fnmc_cfg_t           cfg,
	output fnmc_pkg::fnmc_modctl_t             modctl,
	output logic                               comp_pullup,
	output logic [fnmc_pkg::AMP_W-1:0]         comp_amp,
	output logic                               integral_comp_pulse,
	output logic [fnmc_pkg::IAMP_W-1:0]        integral_comp_amp,
	output logic                               integral_pump_pulse,
	output logic [fnmc_pkg::ACC_W-1:0]         acc_value
);

	logic [1:0]                  rst_sync;
	logic                        rst_n;
	logic                        strobe_s1;
	logic                        strobe_s2;
	logic                        presc_s1;
	logic                        presc_s2;
	logic                        presc_s3;
	logic                        tick;
	logic                        speed_up;
	logic [fnmc_pkg::ACC_W-1:0]  acc_next;
	logic                        acc_wrap;
	logic [3:0]                  mod_value;
	logic                        pending;
	logic                        swap;
	logic                        reload;
	fnmc_pkg::fnmc_ratio_t       phase;
	fnmc_pkg::fnmc_ratio_t       next_phase;
	logic [fnmc_pkg::CNT_W-1:0]  cnt;
	logic [fnmc_pkg::CNT_W-1:0]  next_cnt;
	logic [fnmc_pkg::CNT_W-1:0]  up;
	logic                        next_swap;

	function automatic fnmc_pkg::fnmc_modctl_t fnmc_encode(input fnmc_pkg::fnmc_ratio_t r, input logic sw);
		fnmc_pkg::fnmc_modctl_t m;
		case (r)
			fnmc_pkg::FNMC_R1: m = sw ? fnmc_pkg::MODCTL_R2 : fnmc_pkg::MODCTL_R1;
			fnmc_pkg::FNMC_R2: m = fnmc_pkg::MODCTL_R2;
			fnmc_pkg::FNMC_R3: m = fnmc_pkg::MODCTL_R3;
			fnmc_pkg::FNMC_R4: m = fnmc_pkg::MODCTL_R4;
			default: m = fnmc_pkg::MODCTL_R1;
		endcase
		return m;
	endfunction

	// Reset is released through two flops so every flop leaves reset on the same edge.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_s1 <= 1'b0;
			strobe_s2 <= 1'b0;
		end else begin
			strobe_s1 <= strobe_pin;
			strobe_s2 <= strobe_s1;
		end
	end

	// The third flop only serves the edge detector, never the first stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_s1 <= 1'b0;
			presc_s2 <= 1'b0;
			presc_s3 <= 1'b0;
		end else begin
			presc_s1 <= prescaler_pin;
			presc_s2 <= presc_s1;
			presc_s3 <= presc_s2;
		end
	end
	assign tick = presc_s2 && !presc_s3;

	// Speed-up lags the strobe pin by the synchroniser and its own register, three reference cycles.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_up <= 1'b0;
			integral_pump_pulse <= 1'b0;
		end else begin
			speed_up <= strobe_s2 && speed_word_sel && !cfg.main_disable;
			integral_pump_pulse <= strobe_s2 && speed_word_sel && !cfg.main_disable;
		end
	end

	assign mod_value = (cfg.frac_modulus_select == fnmc_pkg::FRAC_MODULUS_SELECT_SEL_EIGHT) ? fnmc_pkg::MOD_EIGHT : fnmc_pkg::MOD_FIVE;

	fnmc_accum u_accum (
		.clk                 (clk),
		.rst_n               (rst_n),
		.clear               (cfg.main_disable),
		.step                (ref_div_lead),
		.frac_increment      (cfg.frac_increment),
		.frac_modulus_select (cfg.frac_modulus_select),
		.acc                 (acc_value),
		.acc_next            (acc_next),
		.wrap                (acc_wrap)
	);

	fnmc_comp u_comp (
		.clk                 (clk),
		.rst_n               (rst_n),
		.lead                (ref_div_lead && !cfg.main_disable),
		.acc                 (acc_next),
		.speed_up            (speed_up),
		.l_factor            (cfg.l_factor),
		.k_factor            (cfg.k_factor),
		.comp_pullup         (comp_pullup),
		.comp_amp            (comp_amp),
		.integral_comp_pulse (integral_comp_pulse),
		.integral_comp_amp   (integral_comp_amp)
	);

	// Modulus sequencer, advanced once per prescaler output cycle.
	always_comb begin
		next_phase = phase;
		next_cnt = cnt;
		next_swap = swap;
		reload = 1'b0;
		up = cnt + 12'h001;
		if (tick) begin
			case (phase)
				fnmc_pkg::FNMC_R1: begin
					next_swap = 1'b0;
					if (cnt <= 12'h001) begin
						next_phase = fnmc_pkg::FNMC_R2;
						next_cnt = 12'h000;
					end else begin
						next_cnt = cnt - 12'h001;
					end
				end
				fnmc_pkg::FNMC_R2: begin
					next_cnt = up;
					if (cfg.moduli == fnmc_pkg::MODULI_TWO) begin
						reload = (up[7:0] == cfg.n2);
					end else if (up[3:0] == cfg.n2[3:0]) begin
						next_phase = fnmc_pkg::FNMC_R3;
					end
				end
				fnmc_pkg::FNMC_R3: begin
					next_cnt = up;
					if (up[3:0] == cfg.n23) begin
						reload = (cfg.moduli != fnmc_pkg::MODULI_FOUR);
						next_phase = fnmc_pkg::FNMC_R4;
					end
				end
				fnmc_pkg::FNMC_R4: begin
					next_cnt = up;
					reload = (up[3:0] == cfg.n234);
				end
				default: begin
					reload = 1'b1;
				end
			endcase
		end
		if (reload) begin
			next_phase = fnmc_pkg::FNMC_R1;
			next_cnt = cfg.n1;
			next_swap = pending;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= fnmc_pkg::FNMC_R1;
			cnt <= 12'h000;
			swap <= 1'b0;
		end else if (cfg.main_disable) begin
			phase <= fnmc_pkg::FNMC_R1;
			cnt <= cfg.n1;
			swap <= 1'b0;
		end else begin
			phase <= next_phase;
			cnt <= next_cnt;
			swap <= next_swap;
		end
	end

	// A wrap that lands on the reload edge survives: the set wins over the take.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else if (cfg.main_disable) begin
			pending <= 1'b0;
		end else begin
			pending <= acc_wrap || (pending && !reload);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modctl <= fnmc_pkg::MODCTL_RESET;
		end else if (cfg.main_disable) begin
			modctl <= fnmc_pkg::MODCTL_RESET;
		end else begin
			modctl <= fnmc_encode(next_phase, next_swap);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_pulse_two;
		comp_pullup [*2] ##1 !comp_pullup;
	endsequence

	sequence s_lead_start;
		ref_div_lead && !cfg.main_disable ##1 comp_pullup;
	endsequence

	a_acc_step: assert property (ref_div_lead && !cfg.main_disable |=>
		{1'b0, acc_value} == ({1'b0, $past(acc_value)} + {1'b0, $past(cfg.frac_increment)}) % $past(mod_value))
		else $error("Accumulator step wrong.");

	a_acc_range: assert property (ref_div_lead && !cfg.main_disable |=> {1'b0, acc_value} < $past(mod_value))
		else $error("Accumulator outside modulus.");

	a_acc_hold: assert property (!ref_div_lead && !cfg.main_disable |=> $stable(acc_value))
		else $error("Accumulator moved without a comparison cycle.");

	a_wrap_flag: assert property (ref_div_lead && !cfg.main_disable &&
		({1'b0, acc_value} + {1'b0, cfg.frac_increment}) >= mod_value |=> acc_wrap ##1 pending)
		else $error("Overflow did not request N+1.");

	a_clear_disable: assert property (cfg.main_disable |=> acc_value == fnmc_pkg::ACC_RESET && !pending)
		else $error("Accumulator not cleared on disable.");

	a_pulse_width: assert property (s_lead_start |-> s_pulse_two)
		else $error("Compensation pulse width wrong.");

	a_pulse_cause: assert property ($rose(comp_pullup) |-> $past(ref_div_lead))
		else $error("Compensation pulse without divider lead.");

	a_amp_normal: assert property (ref_div_lead && !cfg.main_disable && !speed_up |=>
		comp_amp == {4'h0, $past(acc_next)})
		else $error("Normal compensation amplitude wrong.");

	a_amp_speed: assert property (ref_div_lead && !cfg.main_disable && speed_up |=>
		comp_amp == ({4'h0, $past(acc_next)} << ({1'b0, $past(cfg.l_factor)} + 3'h1)))
		else $error("Speed-up compensation amplitude wrong.");

	// Speed-up is judged at the lead edge, one sample back on the first pulse cycle and two on the second.
	a_int_gate: assert property (integral_comp_pulse |-> comp_pullup &&
		($rose(integral_comp_pulse) ? $past(speed_up) : $past(speed_up, 2)))
		else $error("Integral pulse outside speed-up.");

	a_int_amp: assert property ($rose(integral_comp_pulse) |->
		integral_comp_amp == {4'h0, comp_amp} * {7'h0, $past(cfg.k_factor)})
		else $error("Integral amplitude not scaled by K.");

	a_r1_countdown: assert property (tick && phase == fnmc_pkg::FNMC_R1 && cnt > 12'h001 && !cfg.main_disable |=>
		phase == fnmc_pkg::FNMC_R1 && cnt == $past(cnt) - 12'h001)
		else $error("R1 count-down broken.");

	a_modctl_map: assert property (!$past(cfg.main_disable) |-> modctl ==
		((phase == fnmc_pkg::FNMC_R1 && !swap) ? fnmc_pkg::MODCTL_R1 :
		(phase == fnmc_pkg::FNMC_R3) ? fnmc_pkg::MODCTL_R3 :
		(phase == fnmc_pkg::FNMC_R4) ? fnmc_pkg::MODCTL_R4 : fnmc_pkg::MODCTL_R2))
		else $error("Modulus outputs disagree with phase.");

	a_swap_once: assert property (tick && swap && !cfg.main_disable |=> !swap && modctl == fnmc_pkg::MODCTL_R1 ||
		phase != fnmc_pkg::FNMC_R1)
		else $error("N+1 swap held beyond one R1 cycle.");

	a_swap_apply: assert property (reload && pending && !cfg.main_disable |=>
		swap && modctl == fnmc_pkg::MODCTL_R2)
		else $error("Pending overflow did not stretch the cycle.");

	a_r2_entry: assert property (tick && phase == fnmc_pkg::FNMC_R1 && cnt <= 12'h001 && !cfg.main_disable |=>
		phase == fnmc_pkg::FNMC_R2 && cnt == 12'h000)
		else $error("R1 count-down did not hand over to R2.");

	a_pull_up_only: assert property (!comp_pullup |-> comp_amp == 7'h00 && integral_comp_amp == 11'h000)
		else $error("Compensation amplitude outside the pull-up pulse.");

	a_pump_quiet: assert property (!strobe_s2 |=> !integral_pump_pulse && !speed_up)
		else $error("Integral pump active with strobe low.");

endmodule

// ==== dv/fnmc_prescaler_model.sv ====
// Purpose: Behavioural multimodulus prescaler that stands beyond the modulus outputs.
// Assumes: Each ratio is scaled down to a few reference cycles, well under half the clock rate.
// Notes: Modulus is read at the end of each cycle, as a real prescaler latches it late.
`timescale 1ns/10ps
module fnmc_prescaler_model #(
	parameter int R1_CYC = 8
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire fnmc_pkg::fnmc_modctl_t modctl,
	output logic                        prescaler_pin,
	output fnmc_pkg::fnmc_modctl_t      cyc_ratio,
	output logic                        cyc_start
);
	int cnt;
	int per;

	// The second ratio is one more than the first, so a swap adds exactly one count.
	function automatic int period(input fnmc_pkg::fnmc_modctl_t m);
		case (m)
			fnmc_pkg::MODCTL_R2: return R1_CYC + 1;
			fnmc_pkg::MODCTL_R3: return R1_CYC + 3;
			fnmc_pkg::MODCTL_R4: return R1_CYC + 4;
			default: return R1_CYC;
		endcase
	endfunction

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= R1_CYC - 1;
			per <= R1_CYC;
			cyc_ratio <= fnmc_pkg::MODCTL_R1;
			cyc_start <= 1'b0;
		end else if (cnt >= per - 1) begin
			cnt <= 0;
			per <= period(modctl);
			cyc_ratio <= modctl;
			cyc_start <= 1'b1;
		end else begin
			cnt <= cnt + 1;
			cyc_start <= 1'b0;
		end
	end

	assign prescaler_pin = (cnt < per / 2);
endmodule

// ==== dv/fractional_n_modulus_control_bench.sv ====
// Purpose: Self-checking bench for the fractional-N modulus control block.
// Assumes: Leads come six cycles apart; prescaler is the behavioural model.
// Notes: Expected results are queued by the drivers and popped by the watchers.
`timescale 1ns/10ps
module fractional_n_modulus_control_bench;
	logic                           clk;
	logic                           nrst;
	logic                           strobe_pin;
	logic                           prescaler_pin;
	logic                           ref_div_lead;
	logic                           speed_word_sel;
	fnmc_pkg::fnmc_cfg_t            cfg;
	fnmc_pkg::fnmc_modctl_t         modctl;
	fnmc_pkg::fnmc_modctl_t         cyc_ratio;
	fnmc_pkg::fnmc_modctl_t         last_ratio;
	logic                           cyc_start;
	logic                           comp_pullup;
	logic [fnmc_pkg::AMP_W-1:0]     comp_amp;
	logic                           integral_comp_pulse;
	logic [fnmc_pkg::IAMP_W-1:0]    integral_comp_amp;
	logic                           integral_pump_pulse;
	logic [fnmc_pkg::ACC_W-1:0]     acc_value;
	logic [fnmc_pkg::ACC_W-1:0]     acc_m;
	logic [21:0]                    comp_q[$];
	logic [21:0]                    comp_exp;
	fnmc_pkg::fnmc_modctl_t         mod_q[$];
	logic                           mod_on;
	logic                           synced;
	int                             mismatches;
	int                             n_tests;
	int                             cycles;
	int                             run_len;
	int                             tn1[3] = '{3, 1, 2};
	int                             tn2[3] = '{2, 2, 1};
	int                             tn23[3] = '{2, 3, 3};
	int                             tn234[3] = '{2, 3, 4};

	fnmc_top DUT (
		.clk                 (clk),
		.nrst                (nrst),
		.strobe_pin          (strobe_pin),
		.prescaler_pin       (prescaler_pin),
		.ref_div_lead        (ref_div_lead),
		.speed_word_sel      (speed_word_sel),
		.cfg                 (cfg),
		.modctl              (modctl),
		.comp_pullup         (comp_pullup),
		.comp_amp            (comp_amp),
		.integral_comp_pulse (integral_comp_pulse),
		.integral_comp_amp   (integral_comp_amp),
		.integral_pump_pulse (integral_pump_pulse),
		.acc_value           (acc_value)
	);

	fnmc_prescaler_model presc (
		.clk           (clk),
		.rst_n         (nrst),
		.modctl        (modctl),
		.prescaler_pin (prescaler_pin),
		.cyc_ratio     (cyc_ratio),
		.cyc_start     (cyc_start)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks made: %0d, mismatches: %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Mode 0 strobe low, 1 speed-up word, 2 strobe high on another word.
	task automatic run_acc(input logic sel, input logic [2:0] inc, input int spd, input logic [1:0] l,
			input logic [3:0] k, input int n);
		logic [6:0] amp;
		@(posedge clk);
		#1;
		cfg.frac_modulus_select = sel;
		cfg.frac_increment = inc;
		cfg.l_factor = l;
		cfg.k_factor = k;
		strobe_pin = (spd != 0);
		speed_word_sel = (spd == 1);
		repeat (6) @(posedge clk);
		#1;
		check(integral_pump_pulse, spd == 1);
		for (int j = 0; j < n; j++) begin
			acc_m = 3'((int'(acc_m) + int'(inc)) % (sel ? 8 : 5));
			amp = (spd == 1) ? 7'(acc_m) << (l + 1) : 7'(acc_m);
			comp_q.push_back({acc_m, amp, spd == 1, (spd == 1) ? 11'(amp) * 11'(k) : 11'h000});
			ref_div_lead = 1'b1;
			@(posedge clk);
			#1;
			ref_div_lead = 1'b0;
			repeat (5) @(posedge clk);
			#1;
		end
	endtask

	always @(negedge clk) begin
		if (comp_pullup === 1'b1) begin
			if (run_len == 0) begin
				if (comp_q.size() == 0) check(32'h1, 32'h0);
				else comp_exp = comp_q.pop_front();
			end
			run_len++;
			check({acc_value, comp_amp, integral_comp_pulse, integral_comp_amp}, comp_exp);
		end else if (run_len != 0) begin
			check(run_len, 2);
			run_len = 0;
		end
		if (cyc_start === 1'b1 && mod_on) begin
			if (!synced && cyc_ratio == fnmc_pkg::MODCTL_R1 && last_ratio != fnmc_pkg::MODCTL_R1) synced = 1'b1;
			if (synced && mod_q.size() != 0) check(cyc_ratio, mod_q.pop_front());
			last_ratio = cyc_ratio;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		int w;
		void'($urandom(32'h9436d3a4));
		nrst = 1'b0;
		strobe_pin = 1'b0;
		ref_div_lead = 1'b0;
		speed_word_sel = 1'b0;
		cfg = '0;
		cfg.moduli = fnmc_pkg::MODULI_TWO;
		cfg.n1 = 12'h003;
		cfg.n2 = 8'h02;
		acc_m = fnmc_pkg::ACC_RESET;
		mod_on = 1'b0;
		synced = 1'b0;
		last_ratio = fnmc_pkg::MODCTL_R1;
		mismatches = 0;
		n_tests = 0;
		cycles = 0;
		run_len = 0;
		repeat (10) @(posedge clk);
		#1;
		nrst = 1'b1;
		repeat (4) @(posedge clk);
		run_acc(1'b1, 3'h3, 0, 2'h0, 4'h0, 8);
		run_acc(1'b0, 3'($urandom_range(1, 7)), 0, 2'h0, 4'h0, 6);
		for (int i = 0; i < 4; i++) run_acc(1'($urandom_range(0, 1)), 3'($urandom_range(1, 7)), 1, 2'(i),
			4'($urandom_range(1, 15)), 4);
		run_acc(1'b1, 3'h5, 2, 2'h3, 4'hf, 3);
		@(posedge clk);
		#1;
		strobe_pin = 1'b0;
		cfg.main_disable = 1'b1;
		ref_div_lead = 1'b1;
		@(posedge clk);
		#1;
		ref_div_lead = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check(acc_value, 0);
		check(modctl, fnmc_pkg::MODCTL_R1);
		acc_m = fnmc_pkg::ACC_RESET;
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			#1;
			cfg.main_disable = 1'b1;
			cfg.moduli = 2'(m);
			cfg.n1 = 12'(tn1[m]);
			cfg.n2 = 8'(tn2[m]);
			cfg.n23 = 4'(tn23[m]);
			cfg.n234 = 4'(tn234[m]);
			repeat (4) @(posedge clk);
			#1;
			cfg.main_disable = 1'b0;
			synced = 1'b0;
			last_ratio = fnmc_pkg::MODCTL_R1;
			for (int r = 0; r < 2; r++) begin
				repeat (tn1[m]) mod_q.push_back(fnmc_pkg::MODCTL_R1);
				repeat (tn2[m]) mod_q.push_back(fnmc_pkg::MODCTL_R2);
				repeat (tn23[m] - tn2[m]) mod_q.push_back(fnmc_pkg::MODCTL_R3);
				repeat (tn234[m] - tn23[m]) mod_q.push_back(fnmc_pkg::MODCTL_R4);
			end
			mod_on = 1'b1;
			w = 0;
			while (mod_q.size() != 0 && w < 3000) begin
				@(posedge clk);
				w++;
			end
			check(mod_q.size(), 0);
			mod_on = 1'b0;
			mod_q.delete();
		end
		check(comp_q.size(), 0);
		wrap_up();
	end
endmodule
